/* src/spp_consts.svh */
// Purpose: offsets, field positions and reset values of the shared pin port
// Assumes: register indices are word indices, byte address is four times the index
// Notes:   definitions only
`ifndef SPP_CONSTS_SVH
`define SPP_CONSTS_SVH

// register indices
`define SPP_IDX_FIRST_PORT      8'h00
`define SPP_IDX_SECOND_PORT     8'h01
`define SPP_IDX_PULLUP_CTRL     8'h09
`define SPP_IDX_OPEN_DRAIN_CTRL 8'h0a
`define SPP_IDX_LCD_CTRL        8'h0b
`define SPP_IDX_PERIPH_CTRL     8'h0c

// pullup control fields
`define SPP_PU_LOW_BIT          0
`define SPP_PU_HIGH_BIT         1
`define SPP_PU_FIRST_HIGH_BIT   2
// open-drain control fields
`define SPP_OD_LOW_BIT          0
`define SPP_OD_HIGH_BIT         1
`define SPP_OD_FIRST_HIGH_BIT   2
// lcd control fields
`define SPP_LCD_LOW_BIT         0
`define SPP_LCD_HIGH_BIT        1
// peripheral control fields
`define SPP_PC_EVENT_BIT        0
`define SPP_PC_CONVERTER_POWER_ON_BIT         1
`define SPP_PC_CH_LSB           2
`define SPP_PC_CH_MSB           4
`define SPP_PC_CARRIER_PIN_ENABLE_BIT         5
`define SPP_PC_CARRIER_ACTIVE_BIT         6
`define SPP_PC_CARRIER_IDLE_POLARITY_BIT         7
`define SPP_PC_PULSE_WIDTH_INPUT_ENABLE_BIT         8

// reset values
`define SPP_RST_DIR             8'h00
`define SPP_RST_PULLUP          3'h0
`define SPP_RST_OPEN_DRAIN      3'h0
`define SPP_RST_LCD             2'h0
`define SPP_RST_PERIPH          9'h000
`define SPP_RST_FIRST_DIR       4'h0
`define SPP_RST_LCD_ACTIVE      2'h3

// analog channels owned by first-port bits 4 and 5
`define SPP_CH_BIT4             3'h0
`define SPP_CH_BIT5             3'h1

`endif

/* src/spp_pkg.sv */
// Purpose: shared types of the shared pin port
// Assumes: nothing
// Notes:   constants live in spp_consts.svh
package spp_pkg;
   typedef logic [7:0]  spp_byte_t;
   typedef logic [31:0] spp_word_t;
   typedef logic [2:0]  spp_chan_t;
endpackage

/* src/spp_shared_pin_port.sv */
// Purpose: pin-function logic for first-port bits 4..7 and the LCD-shared second port
// Assumes: APB slave with no wait state; pin levels synchronous to clock
// Notes:   data latches are not reset; option map select comes from elsewhere
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/10ps
`include "spp_consts.svh"

// Functional notes
// - second-port direction bit selects input or output
// - read gives pin for inputs, latch for outputs
// - output latch drives general-purpose output pins
// - writes always land in latch only
// - reset clears second-port direction bits
// - reset leaves output latches untouched
// - lcd nibble mode overrides pins, reads zero
// - nibble pullups follow low/high select bits
// - reset clears all pullup select bits
// - separate open-drain bits per nibble, reset push-pull
// - open-drain drives low or floats; push-pull ignores pullup
// - bit4 analog on channel 0, reads zero
// - bit5 analog on channel 1, reads zero
// - bit4 pin feeds event counter when enabled
// - shared open-drain and pullup bits for bits 4..7
// - bit6 carrier enable gives idle polarity level
// - bit6 outputs carrier pulses when carrier on
// - bit6 stays plain input when direction zero
// - bit7 pin feeds pulse width counter when enabled
module spp_shared_pin_port (
   input  wire logic               clock,
   input  wire logic               nrst,
   input  wire logic               psel,
   input  wire logic               penable,
   input  wire logic               pwrite,
   input  wire logic [11:0]        paddr,
   input  wire spp_pkg::spp_word_t pwdata,
   input  wire logic [3:0]         pstrb,
   output logic                    pready,
   output spp_pkg::spp_word_t      prdata,
   output logic                    pslverr,
   input  wire logic               optionMapSel,
   input  wire logic               carrierPulse,
   input  wire logic [7:0]         secondPortIn,
   output logic [7:0]              secondPortOut,
   output logic [7:0]              secondPortOe,
   output logic [7:0]              secondPortPullup,
   output logic [1:0]              lcdNibbleActive,
   input  wire logic [3:0]         firstPortIn,
   output logic [3:0]              firstPortOut,
   output logic [3:0]              firstPortOe,
   output logic [3:0]              firstPortPullup,
   output logic                    analogInputZero,
   output logic                    analogInputOne,
   output logic                    eventInputPin,
   output logic                    pulseWidthInput
);
   import spp_pkg::*;

   spp_byte_t  secondLatch_q;
   spp_byte_t  secondDir_q;
   logic [3:0] firstLatch_q;
   logic [3:0] firstDir_q;
   logic [2:0] pullupCtrl_q;
   logic [2:0] openDrainCtrl_q;
   logic [1:0] lcdCtrl_q;
   logic [8:0] periphCtrl_q;
   logic       pready_q;
   spp_word_t  prdata_q;
   logic       pslverr_q;

   logic       setupPhase;
   logic       writeDone;
   logic [9:0] regIndex;
   logic       indexHit;
   spp_word_t  readMux;
   logic       secondLow;
   logic       secondHigh;
   logic       firstPullSel;
   logic       firstOdSel;
   logic       converter_power_on;
   spp_chan_t  adChan;
   logic       analog4;
   logic       analog5;
   logic       carrierLevel;
   spp_byte_t  secondRead;
   logic [3:0] firstRead;
   logic [3:0] firstDrive;
   logic [3:0] firstOe_d;
   logic [3:0] firstOut_d;
   logic [3:0] firstPull_d;
   spp_byte_t  secondOe_d;
   spp_byte_t  secondOut_d;
   spp_byte_t  secondPull_d;
   logic [3:0] analogHold;
   logic       wrFirstData;
   logic       wrFirstDir;
   logic       wrSecondData;
   logic       wrSecondDir;
   logic       wrPullup;
   logic       wrOpenDrain;
   logic       wrLcd;
   logic       wrPeriphLow;
   logic       wrPeriphHigh;

   assign setupPhase   = psel & ~penable;
   assign writeDone    = psel & penable & pready_q & pwrite;
   assign regIndex     = paddr[11:2];
   assign secondLow    = lcdCtrl_q[`SPP_LCD_LOW_BIT];
   assign secondHigh   = lcdCtrl_q[`SPP_LCD_HIGH_BIT];
   assign firstPullSel = pullupCtrl_q[`SPP_PU_FIRST_HIGH_BIT];
   assign firstOdSel   = openDrainCtrl_q[`SPP_OD_FIRST_HIGH_BIT];
   assign converter_power_on         = periphCtrl_q[`SPP_PC_CONVERTER_POWER_ON_BIT];
   assign adChan       = periphCtrl_q[`SPP_PC_CH_MSB:`SPP_PC_CH_LSB];
   // analog takeover only while the pin is an input
   assign analog4 = ~firstDir_q[0] & converter_power_on & (adChan == `SPP_CH_BIT4);
   assign analog5 = ~firstDir_q[1] & converter_power_on & (adChan == `SPP_CH_BIT5);

   // bit6 source: latch, idle polarity, or carrier pulse
   always_comb begin
      if (!periphCtrl_q[`SPP_PC_CARRIER_PIN_ENABLE_BIT]) begin
         carrierLevel = firstLatch_q[2];
      end else if (periphCtrl_q[`SPP_PC_CARRIER_ACTIVE_BIT]) begin
         carrierLevel = carrierPulse;
      end else begin
         carrierLevel = periphCtrl_q[`SPP_PC_CARRIER_IDLE_POLARITY_BIT];
      end
   end

   assign firstDrive = {firstLatch_q[3], carrierLevel, firstLatch_q[1:0]};

   assign analogHold = {2'b00, analog5, analog4};

   // first port bits 4..7 pin drive, pullups and read view
   for (genvar g = 0; g < 4; g++) begin : g_first
      always_comb begin
         if (!firstDir_q[g]) begin
            firstOe_d[g]   = 1'b0;
            firstOut_d[g]  = 1'b0;
            firstPull_d[g] = firstPullSel & ~analogHold[g];
            firstRead[g]   = analogHold[g] ? 1'b0 : firstPortIn[g];
         end else if (firstOdSel) begin
            firstOe_d[g]   = ~firstDrive[g];
            firstOut_d[g]  = 1'b0;
            firstPull_d[g] = firstPullSel;
            firstRead[g]   = firstLatch_q[g];
         end else begin
            firstOe_d[g]   = 1'b1;
            firstOut_d[g]  = firstDrive[g];
            firstPull_d[g] = 1'b0;
            firstRead[g]   = firstLatch_q[g];
         end
      end
   end

   // second port pin drive, pullups and read view
   for (genvar g = 0; g < 8; g++) begin : g_second
      logic portMode;
      logic odSel;
      logic puSel;
      assign portMode = (g < 4) ? secondLow : secondHigh;
      assign odSel    = (g < 4) ? openDrainCtrl_q[`SPP_OD_LOW_BIT] : openDrainCtrl_q[`SPP_OD_HIGH_BIT];
      assign puSel    = (g < 4) ? pullupCtrl_q[`SPP_PU_LOW_BIT] : pullupCtrl_q[`SPP_PU_HIGH_BIT];
      always_comb begin
         if (!portMode) begin
            secondOe_d[g]   = 1'b0;
            secondOut_d[g]  = 1'b0;
            secondPull_d[g] = puSel;
            secondRead[g]   = 1'b0;
         end else if (!secondDir_q[g]) begin
            secondOe_d[g]   = 1'b0;
            secondOut_d[g]  = 1'b0;
            secondPull_d[g] = puSel;
            secondRead[g]   = secondPortIn[g];
         end else if (odSel) begin
            secondOe_d[g]   = ~secondLatch_q[g];
            secondOut_d[g]  = 1'b0;
            secondPull_d[g] = puSel;
            secondRead[g]   = secondLatch_q[g];
         end else begin
            secondOe_d[g]   = 1'b1;
            secondOut_d[g]  = secondLatch_q[g];
            secondPull_d[g] = 1'b0;
            secondRead[g]   = secondLatch_q[g];
         end
      end
   end

   // register read decode; option map picks direction over data
   always_comb begin
      indexHit = 1'b1;
      readMux  = '0;
      case (regIndex)
         10'(`SPP_IDX_FIRST_PORT): begin
            readMux[7:4] = optionMapSel ? firstDir_q : firstRead;
         end
         10'(`SPP_IDX_SECOND_PORT): begin
            readMux[7:0] = optionMapSel ? secondDir_q : secondRead;
         end
         10'(`SPP_IDX_PULLUP_CTRL): begin
            readMux[2:0] = pullupCtrl_q;
         end
         10'(`SPP_IDX_OPEN_DRAIN_CTRL): begin
            readMux[2:0] = openDrainCtrl_q;
         end
         10'(`SPP_IDX_LCD_CTRL): begin
            readMux[1:0] = lcdCtrl_q;
         end
         10'(`SPP_IDX_PERIPH_CTRL): begin
            readMux[8:0] = periphCtrl_q;
         end
         default: begin
            indexHit = 1'b0;
         end
      endcase
   end

   // bus answer: no wait state, data and error taken at setup
   always_ff @(posedge clock) begin
      if (!nrst) begin
         pready_q <= 1'b0;
      end else begin
         pready_q <= setupPhase;
      end
   end

   always_ff @(posedge clock) begin
      if (!nrst) begin
         prdata_q <= '0;
      end else begin
         prdata_q <= (setupPhase && !pwrite) ? readMux : 32'h0000_0000;
      end
   end

   always_ff @(posedge clock) begin
      if (!nrst) begin
         pslverr_q <= 1'b0;
      end else begin
         pslverr_q <= setupPhase & ~indexHit;
      end
   end

   // write strobes: lane 0 carries every field except periph bit 8
   assign wrFirstData  = writeDone & pstrb[0] & ~optionMapSel & (regIndex == 10'(`SPP_IDX_FIRST_PORT));
   assign wrFirstDir   = writeDone & pstrb[0] & optionMapSel & (regIndex == 10'(`SPP_IDX_FIRST_PORT));
   assign wrSecondData = writeDone & pstrb[0] & ~optionMapSel & (regIndex == 10'(`SPP_IDX_SECOND_PORT));
   assign wrSecondDir  = writeDone & pstrb[0] & optionMapSel & (regIndex == 10'(`SPP_IDX_SECOND_PORT));
   assign wrPullup     = writeDone & pstrb[0] & (regIndex == 10'(`SPP_IDX_PULLUP_CTRL));
   assign wrOpenDrain  = writeDone & pstrb[0] & (regIndex == 10'(`SPP_IDX_OPEN_DRAIN_CTRL));
   assign wrLcd        = writeDone & pstrb[0] & (regIndex == 10'(`SPP_IDX_LCD_CTRL));
   assign wrPeriphLow  = writeDone & pstrb[0] & (regIndex == 10'(`SPP_IDX_PERIPH_CTRL));
   assign wrPeriphHigh = writeDone & pstrb[1] & (regIndex == 10'(`SPP_IDX_PERIPH_CTRL));

   // data latches carry no reset; writes land here whatever owns the pin
   always_ff @(posedge clock) begin
      if (wrSecondData) begin
         secondLatch_q <= pwdata[7:0];
      end
   end

   always_ff @(posedge clock) begin
      if (wrFirstData) begin
         firstLatch_q <= pwdata[7:4];
      end
   end

   // direction registers sit behind the option map select
   always_ff @(posedge clock) begin
      if (!nrst) begin
         secondDir_q <= `SPP_RST_DIR;
      end else if (wrSecondDir) begin
         secondDir_q <= pwdata[7:0];
      end
   end

   always_ff @(posedge clock) begin
      if (!nrst) begin
         firstDir_q <= `SPP_RST_FIRST_DIR;
      end else if (wrFirstDir) begin
         firstDir_q <= pwdata[7:4];
      end
   end

   // control registers
   always_ff @(posedge clock) begin
      if (!nrst) begin
         pullupCtrl_q <= `SPP_RST_PULLUP;
      end else if (wrPullup) begin
         pullupCtrl_q <= pwdata[2:0];
      end
   end

   always_ff @(posedge clock) begin
      if (!nrst) begin
         openDrainCtrl_q <= `SPP_RST_OPEN_DRAIN;
      end else if (wrOpenDrain) begin
         openDrainCtrl_q <= pwdata[2:0];
      end
   end

   always_ff @(posedge clock) begin
      if (!nrst) begin
         lcdCtrl_q <= `SPP_RST_LCD;
      end else if (wrLcd) begin
         lcdCtrl_q <= pwdata[1:0];
      end
   end

   always_ff @(posedge clock) begin
      if (!nrst) begin
         periphCtrl_q <= `SPP_RST_PERIPH;
      end else begin
         if (wrPeriphLow) begin
            periphCtrl_q[7:0] <= pwdata[7:0];
         end
         if (wrPeriphHigh) begin
            periphCtrl_q[8] <= pwdata[8];
         end
      end
   end

   // registered pin side: second port
   always_ff @(posedge clock) begin
      if (!nrst) begin
         secondPortOut    <= 8'h00;
         secondPortOe     <= 8'h00;
         secondPortPullup <= 8'h00;
      end else begin
         secondPortOut    <= secondOut_d;
         secondPortOe     <= secondOe_d;
         secondPortPullup <= secondPull_d;
      end
   end

   always_ff @(posedge clock) begin
      if (!nrst) begin
         lcdNibbleActive <= `SPP_RST_LCD_ACTIVE;
      end else begin
         lcdNibbleActive <= {~secondHigh, ~secondLow};
      end
   end

   // registered pin side: first port bits 4..7
   always_ff @(posedge clock) begin
      if (!nrst) begin
         firstPortOut    <= 4'h0;
         firstPortOe     <= 4'h0;
         firstPortPullup <= 4'h0;
      end else begin
         firstPortOut    <= firstOut_d;
         firstPortOe     <= firstOe_d;
         firstPortPullup <= firstPull_d;
      end
   end

   always_ff @(posedge clock) begin
      if (!nrst) begin
         analogInputZero <= 1'b0;
         analogInputOne  <= 1'b0;
      end else begin
         analogInputZero <= analog4;
         analogInputOne  <= analog5;
      end
   end

   // the pin level itself feeds the counters in either direction
   always_ff @(posedge clock) begin
      if (!nrst) begin
         eventInputPin   <= 1'b0;
         pulseWidthInput <= 1'b0;
      end else begin
         eventInputPin   <= periphCtrl_q[`SPP_PC_EVENT_BIT] & firstPortIn[0];
         pulseWidthInput <= periphCtrl_q[`SPP_PC_PULSE_WIDTH_INPUT_ENABLE_BIT] & firstPortIn[3];
      end
   end

   assign pready  = pready_q;
   assign prdata  = prdata_q;
   assign pslverr = pslverr_q;
endmodule

/* bench/spp_port_properties.sv */
// Purpose: port-level properties of the shared pin port
// Assumes: one clock domain, synchronous active-low reset
// Notes:   bound to the top module after the checker
`timescale 1ns/10ps
module spp_port_checker (
   input wire logic               clock,
   input wire logic               nrst,
   input wire logic               psel,
   input wire logic               penable,
   input wire logic               pready,
   input wire spp_pkg::spp_word_t prdata,
   input wire logic               pslverr,
   input wire logic [7:0]         secondPortOut,
   input wire logic [7:0]         secondPortOe,
   input wire logic [7:0]         secondPortPullup,
   input wire logic [1:0]         lcdNibbleActive,
   input wire logic [3:0]         firstPortIn,
   input wire logic [3:0]         firstPortOe,
   input wire logic [3:0]         firstPortPullup,
   input wire logic               analogInputZero,
   input wire logic               analogInputOne,
   input wire logic               eventInputPin,
   input wire logic               pulseWidthInput
);
   import spp_pkg::*;
   default clocking @(posedge clock); endclocking
   default disable iff (!nrst);
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_answer;
      pready ##1 !pready;
   endsequence
   a_ready_once: assert property (s_setup |=> s_answer)
      else $error("ready not one cycle after setup");
   a_ready_access: assert property (pready |-> psel && penable)
      else $error("ready outside access phase");
   a_err_ready: assert property (pslverr |-> pready)
      else $error("error without ready");
   a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
      else $error("read data outside answer");
   a_lcd_low_idle: assert property (lcdNibbleActive[0] |-> secondPortOe[3:0] == 4'h0)
      else $error("low nibble driven in lcd mode");
   a_lcd_high_idle: assert property (lcdNibbleActive[1] |-> secondPortOe[7:4] == 4'h0)
      else $error("high nibble driven in lcd mode");
   a_pp_no_pullup: assert property ((secondPortOe & secondPortOut & secondPortPullup) == 8'h00)
      else $error("pullup on push-pull output");
   a_analog_zero: assert property (analogInputZero |-> !firstPortOe[0] && !firstPortPullup[0])
      else $error("analog pin four not released");
   a_analog_one: assert property (analogInputOne |-> !firstPortOe[1] && !firstPortPullup[1]
                                  && !analogInputZero)
      else $error("analog pin five not released");
   a_event_pin: assert property (eventInputPin |-> $past(firstPortIn[0]))
      else $error("event input without pin level");
   a_pulse_pin: assert property (pulseWidthInput |-> $past(firstPortIn[3]))
      else $error("pulse input without pin level");
   a_reset_state: assert property ($rose(nrst) |-> lcdNibbleActive == 2'h3 && secondPortOe == 8'h00
                                   && secondPortPullup == 8'h00)
      else $error("wrong state after reset");
endmodule
bind spp_shared_pin_port spp_port_checker i_spp_port_checker (.clock, .nrst, .psel, .penable, .pready,
   .prdata, .pslverr, .secondPortOut, .secondPortOe, .secondPortPullup, .lcdNibbleActive, .firstPortIn,
   .firstPortOe, .firstPortPullup, .analogInputZero, .analogInputOne, .eventInputPin, .pulseWidthInput);

/* bench/spp_pin_model.sv */
// Purpose: external circuit on both ports
// Assumes: external drivers give digital levels
// Notes:   a driving device output wins over the external driver
`timescale 1ns/10ps
module spp_pin_model (
   input  wire logic [7:0] bOut,
   input  wire logic [7:0] bOe,
   input  wire logic [7:0] bExt,
   output logic [7:0]      bIn,
   input  wire logic [3:0] aOut,
   input  wire logic [3:0] aOe,
   input  wire logic [3:0] aExt,
   output logic [3:0]      aIn
);
   // digital levels only, never an analog voltage
   assign bIn = (bOe & bOut) | (~bOe & bExt);
   assign aIn = (aOe & aOut) | (~aOe & aExt);
endmodule

/* bench/testbench.sv */
// Purpose: self-checking bench of the shared pin port
// Assumes: pins resolved by spp_pin_model
// Notes:   random stimulus from a fixed seed
`timescale 1ns/10ps
module testbench;
   import spp_pkg::*;
   logic        clock, nrst, psel, penable, pwrite, optionMapSel, carrierPulse, lvl, er;
   logic        pready, pslverr, analogInputZero, analogInputOne, eventInputPin, pulseWidthInput;
   logic [11:0] paddr;
   logic [1:0]  lcdNibbleActive, lcd;
   logic [2:0]  od, pu;
   logic [3:0]  firstPortIn, firstPortOut, firstPortOe, firstPortPullup, aExt, v, pin;
   spp_byte_t   secondPortIn, secondPortOut, secondPortOe, secondPortPullup, bExt, dir, lat;
   spp_word_t   pwdata, prdata, rd;
   int          n_mismatch, checked;

   spp_shared_pin_port i_spp_shared_pin_port (.clock, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata,
      .pstrb(4'hf), .pready, .prdata, .pslverr, .optionMapSel, .carrierPulse, .secondPortIn, .secondPortOut,
      .secondPortOe, .secondPortPullup, .lcdNibbleActive, .firstPortIn, .firstPortOut, .firstPortOe,
      .firstPortPullup, .analogInputZero, .analogInputOne, .eventInputPin, .pulseWidthInput);
   spp_pin_model i_spp_pin_model (.bOut(secondPortOut), .bOe(secondPortOe), .bExt, .bIn(secondPortIn),
      .aOut(firstPortOut), .aOe(firstPortOe), .aExt, .aIn(firstPortIn));

   always #10 clock = ~clock;

   task automatic test_done;
      $display("checks %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic chk(input logic ok, input string msg);
      checked++;
      if (ok !== 1'b1) begin
         n_mismatch++;
         $display("mismatch at %0t: %s", $time, msg);
      end
   endtask

   task automatic apb(input logic [7:0] idx, input logic sel, input logic w, input spp_word_t d);
      int n;
      @(posedge clock);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      optionMapSel <= sel;
      paddr <= {2'b00, idx, 2'b00};
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      n = 0;
      @(posedge clock);
      while (pready !== 1'b1 && n < 20) begin
         @(posedge clock);
         n++;
      end
      chk(n < 20, "no ready");
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic settle;
      repeat (2) @(posedge clock);
      #1;
   endtask

   function automatic spp_byte_t nib(input logic [1:0] m);
      return {{4{m[1]}}, {4{m[0]}}};
   endfunction

   task automatic chk_b;
      settle;
      apb(8'h01, 1'b0, 1'b0, 32'h0);
      chk(rd[7:0] === (nib(lcd) & ((dir & lat) | (~dir & bExt))), "port read");
      chk(secondPortOe === (nib(lcd) & dir & (~nib(od[1:0]) | ~lat)), "drive enable");
      chk((secondPortOut & secondPortOe) === (nib(lcd) & dir & ~nib(od[1:0]) & lat), "level");
      chk(secondPortPullup === (nib(pu[1:0]) & ~(nib(lcd) & dir & ~nib(od[1:0]))), "pullup");
      chk(lcdNibbleActive === ~lcd, "lcd mode");
   endtask

   initial begin
      #400000;
      n_mismatch++;
      $display("mismatch at %0t: watchdog", $time);
      test_done;
   end

   initial begin
      clock = 1'b0;
      nrst = 1'b0;
      {psel, penable, pwrite, optionMapSel, carrierPulse} = 5'h0;
      paddr = 12'h0;
      pwdata = 32'h0;
      {aExt, bExt} = 12'h0;
      n_mismatch = 0;
      checked = 0;
      void'($urandom(72855));
      repeat (20) @(posedge clock);
      nrst <= 1'b1;
      {dir, lcd, od, pu} = '0;
      lat = 'x;
      apb(8'h01, 1'b1, 1'b0, 32'h0);
      chk(rd === 32'h0, "direction reset");
      chk_b;
      for (int i = 0; i < 12; i++) begin
         {dir, lat, od, lcd} = {8'($urandom), 8'($urandom), 3'($urandom), 2'($urandom)};
         if (i == 0) {dir, lat, od, lcd} = {8'hff, 8'h0f, 3'h3, 2'h3};
         pu = 3'($urandom) & {1'b1, lcd};
         bExt <= 8'($urandom);
         apb(8'h01, 1'b0, 1'b1, 32'(lat));
         apb(8'h01, 1'b1, 1'b1, 32'(dir));
         apb(8'h0a, 1'b0, 1'b1, 32'(od));
         apb(8'h09, 1'b0, 1'b1, 32'(pu));
         apb(8'h0b, 1'b0, 1'b1, 32'(lcd));
         chk_b;
      end
      apb(8'h01, 1'b0, 1'b1, 32'hc3);
      nrst <= 1'b0;
      repeat (2) @(posedge clock);
      nrst <= 1'b1;
      apb(8'h0b, 1'b0, 1'b1, 32'h3);
      apb(8'h01, 1'b1, 1'b1, 32'hff);
      apb(8'h01, 1'b0, 1'b0, 32'h0);
      chk(rd[7:0] === 8'hc3, "latch kept");
      apb(8'h09, 1'b0, 1'b1, 32'h4);
      apb(8'h00, 1'b1, 1'b1, 32'h0);
      aExt <= 4'hf;
      for (int ch = 0; ch < 8; ch++) begin
         apb(8'h0c, 1'b0, 1'b1, 32'(ch * 4 + 2));
         settle;
         chk(analogInputZero === (ch == 0) && analogInputOne === (ch == 1), "analog");
         chk(firstPortPullup === {2'b11, ch != 1, ch != 0}, "analog pullup");
         apb(8'h00, 1'b0, 1'b0, 32'h0);
         chk(rd[7:4] === {2'b11, ch != 1, ch != 0}, "analog read");
      end
      apb(8'h0c, 1'b0, 1'b1, 32'h101);
      for (int k = 0; k < 2; k++) begin
         v = 4'($urandom);
         aExt <= 4'($urandom);
         apb(8'h00, 1'b0, 1'b1, 32'({v, 4'h0}));
         apb(8'h00, 1'b1, 1'b1, k ? 32'hf0 : 32'h0);
         settle;
         pin = k ? v : aExt;
         chk(eventInputPin === pin[0] && pulseWidthInput === pin[3], "event/pulse");
      end
      chk(firstPortOe === 4'hf && firstPortOut === v, "first out");
      for (int j = 0; j < 8; j++) begin
         carrierPulse <= 1'($urandom);
         apb(8'h0a, 1'b0, 1'b1, 32'(j & 4));
         apb(8'h0c, 1'b0, 1'b1, 32'({j[0], j[1], 6'h20}));
         settle;
         lvl = j[1] ? carrierPulse : j[0];
         chk(j[2] ? (firstPortOe[2] === ~lvl) : (firstPortOe[2] && firstPortOut[2] === lvl), "carrier");
      end
      apb(8'h00, 1'b1, 1'b1, 32'h0);
      settle;
      chk(firstPortOe === 4'h0, "input");
      apb(8'h3f, 1'b0, 1'b0, 32'h0);
      chk(er === 1'b1 && rd === 32'h0, "unmapped");
      test_done;
   end
endmodule
